// [pkg/vcq_cfg.svh]
/*
  Constants for the virtual CPU interface query and acknowledge register logic:
  system register encodings, field positions and special identifiers.
  Assumes it is included by its bare name from the package and the design.
*/
// Behaviour
// - Group 1 EOI with route zero goes physical.
// - Group 0 query returns highest pending identifier.
// - Group 1 query returns highest pending identifier.
// - Group 0 virtual registers only when route set.
// - Group 1 virtual registers only when route set.
// - Interface enable zero traps to guest level.
// - Trap-all bits trap their group to hypervisor.
// - Group 0 acknowledge read activates signalled interrupt.
// - Acknowledge only when priority sufficient and acknowledgeable.
// - Unobservable pending reads return identifier 1023.
// - Identifier 16 or 24 bits, upper zero.
// - Acknowledge reads self-synchronise while interrupts masked.
// - Query and acknowledge registers are 32 bits.
// - Read-only, guest level only, Non-secure only; the group 1 EOI register is write-only.
// - Decode op0 11, op1 000, CRn 1100.
// - Split mode zero also deactivates on EOI.
`ifndef VCQ_CFG_SVH
`define VCQ_CFG_SVH

// Common encoding fields.
`define VCQ_OP0          2'h3
`define VCQ_OP1          3'h0
`define VCQ_CRN          4'hc
// Group selecting CRm values.
`define VCQ_CRM_G0       4'h8
`define VCQ_CRM_G1       4'hc
// op2 values.
`define VCQ_OP2_ACK      3'h0
`define VCQ_OP2_EOI      3'h1
`define VCQ_OP2_QUERY    3'h2
// Identifier field.
`define VCQ_ID_MSB       23
`define VCQ_ID_NARROW    16
`define VCQ_SPURIOUS_ID  24'h0003ff
// Reset value of the read data register.
`define VCQ_RDATA_RST    32'h00000000

`endif

// [pkg/vcq_pkg.sv]
/*
  Types for the virtual CPU interface query and acknowledge register logic.
  Assumes the constants header is on the include path.
*/
`include "vcq_cfg.svh"
package vcq_pkg;
  // Where an access ends up.
  typedef enum logic [2:0] {
    VCQ_DST_NONE,
    VCQ_DST_VIRT,
    VCQ_DST_PHYS,
    VCQ_DST_TRAP_GUEST,
    VCQ_DST_TRAP_HYP
  } vcq_dst_t;
  // Which register the encoding selects.
  typedef enum logic [2:0] {
    VCQ_SEL_NONE,
    VCQ_SEL_QUERY_G0,
    VCQ_SEL_QUERY_G1,
    VCQ_SEL_ACK_G0,
    VCQ_SEL_EOI_G1
  } vcq_sel_t;
endpackage

// [design/vcq_regs.sv]
/*
  Virtual CPU interface register logic for guest-level system register accesses:
  pending queries, group 0 acknowledge and group 1 end-of-interrupt routing.
  Assumes the core presents one access per request pulse on the core clock and
  that the prioritisation logic outside supplies the highest pending interrupts.
*/
`include "vcq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module vcq_regs #(
  parameter int ID_WIDTH = 24  // Physically stored identifier width.
) (
  // Clock and reset.
  input  wire logic               core_clk_i,
  input  wire logic               sys_rst_i,
  // System register access from the processing element.
  input  wire logic               req_i,
  input  wire logic               write_i,
  input  wire logic [1:0]         op0_i,
  input  wire logic [2:0]         op1_i,
  input  wire logic [3:0]         crn_i,
  input  wire logic [3:0]         crm_i,
  input  wire logic [2:0]         op2_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               nonsecure_i,
  input  wire logic               guest_level_i,
  input  wire logic               irq_masked_i,
  // Routing and trap controls.
  input  wire logic               group0_virtual_route_i,
  input  wire logic               group1_virtual_route_i,
  input  wire logic               sysreg_interface_enable_i,
  input  wire logic               trap_all_group0_i,
  input  wire logic               trap_all_group1_i,
  input  wire logic               identifier_width_field_i,
  input  wire logic               split_completion_mode_i,
  // Highest pending virtual interrupts from the list logic.
  input  wire logic               hp_g0_valid_i,
  input  wire logic [23:0]        hp_g0_id_i,
  input  wire logic               hp_g0_signalable_i,
  input  wire logic               hp_g0_ackable_i,
  input  wire logic               hp_g1_valid_i,
  input  wire logic [23:0]        hp_g1_id_i,
  // Answer to the processing element.
  output logic                    ack_o,
  output logic [31:0]             rdata_o,
  output vcq_pkg::vcq_dst_t       dst_o,
  // Effects on the virtual interrupt state.
  output logic                    activate_o,
  output logic [23:0]             activate_id_o,
  output logic                    drop_prio_o,
  output logic                    deactivate_o,
  output logic [23:0]             eoi_id_o,
  output logic                    sync_o,
  // Forward to the physical interface.
  output logic                    phys_req_o,
  output logic                    phys_write_o,
  output logic [31:0]             phys_wdata_o
);
  import vcq_pkg::*;

  // Registered answers and effects.
  logic              ack_reg,       ack_next;
  logic [31:0]       rdata_reg,     rdata_next;
  vcq_dst_t          dst_reg,       dst_next;
  logic              act_reg,       act_next;
  logic [23:0]       act_id_reg,    act_id_next;
  logic              drop_reg,      drop_next;
  logic              deact_reg,     deact_next;
  logic [23:0]       eoi_id_reg,    eoi_id_next;
  logic              sync_reg,      sync_next;
  logic              preq_reg,      preq_next;
  logic              pwr_reg,       pwr_next;
  logic [31:0]       pwdata_reg,    pwdata_next;

  // Decoded selection and helpers.
  vcq_sel_t          sel;           // Register that the encoding names.
  logic              grp1;          // Selected register is group 1.
  logic              route_virt;    // Group route bit directs to virtual copy.
  logic              trap_all;      // Trap-all bit of the selected group.
  logic              access_ok;     // Direction matches register access kind.
  logic [31:0]       eoi_clip;      // Written identifier clipped to the implemented width.

  // Clip an identifier to the implemented width; bits 31:24 always zero.
  function automatic logic [31:0] vcq_clip(input logic [23:0] id, input logic wide);
    logic [31:0] res;
    res = {8'h00, id};
    if (!wide || ID_WIDTH <= `VCQ_ID_NARROW) begin
      res[`VCQ_ID_MSB:`VCQ_ID_NARROW] = 8'h00;
    end
    return res;
  endfunction

  // Decode of the fixed encoding fields into a register selection.
  always_comb begin
    sel = VCQ_SEL_NONE;
    if (op0_i == `VCQ_OP0 && op1_i == `VCQ_OP1 && crn_i == `VCQ_CRN) begin
      if (crm_i == `VCQ_CRM_G0 && op2_i == `VCQ_OP2_QUERY) begin
        sel = VCQ_SEL_QUERY_G0;
      end else if (crm_i == `VCQ_CRM_G1 && op2_i == `VCQ_OP2_QUERY) begin
        sel = VCQ_SEL_QUERY_G1;
      end else if (crm_i == `VCQ_CRM_G0 && op2_i == `VCQ_OP2_ACK) begin
        sel = VCQ_SEL_ACK_G0;
      end else if (crm_i == `VCQ_CRM_G1 && op2_i == `VCQ_OP2_EOI) begin
        sel = VCQ_SEL_EOI_G1;
      end
    end
  end

  // Group-dependent controls of the selected register.
  always_comb begin
    grp1       = (sel == VCQ_SEL_QUERY_G1) || (sel == VCQ_SEL_EOI_G1);
    route_virt = grp1 ? group1_virtual_route_i : group0_virtual_route_i;
    trap_all   = grp1 ? trap_all_group1_i : trap_all_group0_i;
    // The end-of-interrupt register is write-only; the rest are read-only.
    access_ok  = (sel == VCQ_SEL_EOI_G1) ? write_i : !write_i;
  end

  // Routing, answer data and side effects of one access.
  always_comb begin
    ack_next    = 1'b0;
    rdata_next  = `VCQ_RDATA_RST;
    dst_next    = VCQ_DST_NONE;
    act_next    = 1'b0;
    act_id_next = act_id_reg;
    drop_next   = 1'b0;
    deact_next  = 1'b0;
    eoi_id_next = eoi_id_reg;
    sync_next   = 1'b0;
    preq_next   = 1'b0;
    pwr_next    = pwr_reg;
    pwdata_next = pwdata_reg;
    // Clipped once here, because a function result cannot be part-selected directly.
    eoi_clip    = vcq_clip(wdata_i[23:0], identifier_width_field_i);
    if (req_i) begin
      ack_next = 1'b1;
      if (sel == VCQ_SEL_NONE || !nonsecure_i || !guest_level_i || !access_ok) begin
        // Other levels or security states see nothing here; reads return zero.
        dst_next = VCQ_DST_NONE;
      end else if (!route_virt) begin
        // Route bit clear: the same encoding reaches the physical register.
        dst_next    = VCQ_DST_PHYS;
        preq_next   = 1'b1;
        pwr_next    = write_i;
        pwdata_next = wdata_i;
      end else if (!sysreg_interface_enable_i) begin
        // Disabled interface traps to the guest level before trap-all.
        dst_next = VCQ_DST_TRAP_GUEST;
      end else if (trap_all) begin
        dst_next = VCQ_DST_TRAP_HYP;
      end else begin
        dst_next = VCQ_DST_VIRT;
        unique case (sel)
          VCQ_SEL_QUERY_G0: begin
            // Queries never touch pending or active state.
            rdata_next = vcq_clip(hp_g0_valid_i ? hp_g0_id_i : `VCQ_SPURIOUS_ID,
                                  identifier_width_field_i);
          end
          VCQ_SEL_QUERY_G1: begin
            rdata_next = vcq_clip(hp_g1_valid_i ? hp_g1_id_i : `VCQ_SPURIOUS_ID,
                                  identifier_width_field_i);
          end
          VCQ_SEL_ACK_G0: begin
            if (hp_g0_valid_i && hp_g0_signalable_i && hp_g0_ackable_i) begin
              rdata_next  = vcq_clip(hp_g0_id_i, identifier_width_field_i);
              act_next    = 1'b1;
              act_id_next = hp_g0_id_i;
            end else begin
              rdata_next = vcq_clip(`VCQ_SPURIOUS_ID, identifier_width_field_i);
            end
            // While masked, sync_o is raised with the answer, in the same cycle as the activation.
            sync_next = irq_masked_i;
          end
          VCQ_SEL_EOI_G1: begin
            // Trusts the identifier to match the last valid acknowledge.
            drop_next   = 1'b1;
            deact_next  = !split_completion_mode_i;
            eoi_id_next = eoi_clip[23:0];
          end
          default: begin
            dst_next = VCQ_DST_NONE;
          end
        endcase
      end
    end
  end

  // State registers; all outputs come straight from these.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_reg    <= 1'b0;
      rdata_reg  <= `VCQ_RDATA_RST;
      dst_reg    <= VCQ_DST_NONE;
      act_reg    <= 1'b0;
      act_id_reg <= 24'h000000;
      drop_reg   <= 1'b0;
      deact_reg  <= 1'b0;
      eoi_id_reg <= 24'h000000;
      sync_reg   <= 1'b0;
      preq_reg   <= 1'b0;
      pwr_reg    <= 1'b0;
      pwdata_reg <= 32'h00000000;
    end else begin
      ack_reg    <= ack_next;
      rdata_reg  <= rdata_next;
      dst_reg    <= dst_next;
      act_reg    <= act_next;
      act_id_reg <= act_id_next;
      drop_reg   <= drop_next;
      deact_reg  <= deact_next;
      eoi_id_reg <= eoi_id_next;
      sync_reg   <= sync_next;
      preq_reg   <= preq_next;
      pwr_reg    <= pwr_next;
      pwdata_reg <= pwdata_next;
    end
  end

  // Output wiring from the registers.
  assign ack_o         = ack_reg;
  assign rdata_o       = rdata_reg;
  assign dst_o         = dst_reg;
  assign activate_o    = act_reg;
  assign activate_id_o = act_id_reg;
  assign drop_prio_o   = drop_reg;
  assign deactivate_o  = deact_reg;
  assign eoi_id_o      = eoi_id_reg;
  assign sync_o        = sync_reg;
  assign phys_req_o    = preq_reg;
  assign phys_write_o  = pwr_reg;
  assign phys_wdata_o  = pwdata_reg;
endmodule
`default_nettype wire

// [verification/vcq_regs_checker.sv]
/* Assertions on the query, acknowledge and end-of-interrupt routing logic.
   Sees only the ports of vcq_regs and is bound to it by name. */
`timescale 1ns/100ps
`default_nettype none
module vcq_regs_checker (
  // Clock, reset and access lines.
  input wire logic        core_clk_i, sys_rst_i, req_i, write_i, nonsecure_i, guest_level_i,
  input wire logic [1:0]  op0_i,
  input wire logic [2:0]  op1_i, op2_i,
  input wire logic [3:0]  crn_i, crm_i,
  // Routing, trap controls, group 0 highest pending and the activated identifier.
  input wire logic        group0_virtual_route_i, group1_virtual_route_i, sysreg_interface_enable_i,
  input wire logic        trap_all_group0_i, trap_all_group1_i, split_completion_mode_i,
  input wire logic        hp_g0_valid_i, hp_g0_signalable_i, hp_g0_ackable_i,
  input wire logic [23:0] hp_g0_id_i, activate_id_o,
  // Answer and effects.
  input wire logic        ack_o, activate_o, drop_prio_o, deactivate_o, phys_req_o,
  input wire logic [31:0] rdata_o,
  input wire vcq_pkg::vcq_dst_t dst_o
);
  import vcq_pkg::*;
  // Legal guest accesses per group; refused ones match none of these.
  wire logic acc = req_i && nonsecure_i && guest_level_i && op0_i == 2'h3 && op1_i == 3'h0 && crn_i == 4'hc;
  wire logic g0  = acc && !write_i && crm_i == 4'h8 && (op2_i == 3'h2 || op2_i == 3'h0);
  wire logic g1  = acc && crm_i == 4'hc && (write_i ? op2_i == 3'h1 : op2_i == 3'h2);
  wire logic en  = sysreg_interface_enable_i;
  wire logic v0  = g0 && group0_virtual_route_i && en && !trap_all_group0_i;
  wire logic v1  = g1 && group1_virtual_route_i && en && !trap_all_group1_i;
  logic [23:0] id_q;  // Identifier seen at the taking edge, kept to avoid slicing a past value.
  always_ff @(posedge core_clk_i) begin
    id_q <= hp_g0_id_i;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_answer_next_cycle: assert property (req_i |=> ack_o) else $error("access not answered next cycle");
  a_refuse_bad_write: assert property (req_i && write_i && !g1 |=> dst_o == VCQ_DST_NONE && rdata_o == 32'h0)
    else $error("write to read-only place not refused");
  a_route0_phys: assert property (g0 && !group0_virtual_route_i |=> dst_o == VCQ_DST_PHYS && phys_req_o)
    else $error("group 0 access with route clear not physical");
  a_route1_phys: assert property (g1 && !group1_virtual_route_i |=> dst_o == VCQ_DST_PHYS && phys_req_o)
    else $error("group 1 access with route clear not physical");
  a_trap_guest_level: assert property (!en && (g0 && group0_virtual_route_i || g1 && group1_virtual_route_i)
    |=> dst_o == VCQ_DST_TRAP_GUEST) else $error("disabled interface did not trap to guest");
  a_trap_hyp_level: assert property (en && (g0 && group0_virtual_route_i && trap_all_group0_i
    || g1 && group1_virtual_route_i && trap_all_group1_i) |=> dst_o == VCQ_DST_TRAP_HYP)
    else $error("trap-all did not trap to hypervisor");
  a_ack_activates: assert property (v0 && op2_i == 3'h0 && hp_g0_valid_i && hp_g0_signalable_i && hp_g0_ackable_i
    |=> activate_o && activate_id_o[15:0] == id_q[15:0] && rdata_o[15:0] == id_q[15:0])
    else $error("acknowledge did not activate the pending identifier");
  a_ack_spurious: assert property (v0 && !hp_g0_valid_i |=> !activate_o && rdata_o == 32'h3ff)
    else $error("empty pending read not 1023");
  a_eoi_split_mode: assert property (v1 && write_i |=> drop_prio_o && deactivate_o == !$past(split_completion_mode_i))
    else $error("end of interrupt effects wrong for split mode");
endmodule
bind vcq_regs vcq_regs_checker u_vcq_regs_checker (.*);
`default_nettype wire

// [verification/vcq_pe_model.sv]
/* Processing element model issuing guest system register accesses.
   Assumes the design takes a request at the rising edge of core_clk_i. */
`timescale 1ns/100ps
`default_nettype none
module vcq_pe_model (
  // Clock and access lines.
  input  wire logic   core_clk_i,
  output logic        req_o, write_o, ns_o, guest_o,
  output logic [1:0]  op0_o,
  output logic [2:0]  op1_o, op2_o,
  output logic [3:0]  crn_o, crm_o,
  output logic [31:0] wdata_o
);
  // All lines quiet at time zero.
  initial begin
    {req_o, write_o, ns_o, guest_o, op0_o, op1_o, op2_o, crn_o, crm_o, wdata_o} = '0;
  end
  // Request set just after an edge, held through the taking edge; results are settled on return.
  task automatic access(input logic w, s, g, input logic [3:0] cn, cm, input logic [2:0] o2, input logic [31:0] d);
    {req_o, write_o, ns_o, guest_o, op0_o, op1_o, crn_o, crm_o, op2_o, wdata_o} = {1'b1, w, s, g, 2'h3, 3'h0, cn, cm, o2, d};
    @(posedge core_clk_i);
    #1;
  endtask
  // Data inverts on release so that a stale word can never pass for a fresh one.
  task automatic release_bus();
    req_o = 1'b0;
    wdata_o = ~wdata_o;
  endtask
endmodule
`default_nettype wire

// [verification/tb_virtual_cpu_if_ack_query_regs.sv]
/* Self-checking bench for vcq_regs with a queue-free reference model.
   Assumes the processing element model and the bound checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_virtual_cpu_if_ack_query_regs;
  import vcq_pkg::*;
  logic core_clk_i, sys_rst_i, req_i, write_i, nonsecure_i, guest_level_i, irq_masked_i, hp_g1_valid_i;
  logic group0_virtual_route_i, group1_virtual_route_i, sysreg_interface_enable_i, trap_all_group0_i;
  logic trap_all_group1_i, identifier_width_field_i, split_completion_mode_i, hp_g0_valid_i;
  logic hp_g0_signalable_i, hp_g0_ackable_i, ack_o, activate_o, drop_prio_o, deactivate_o, sync_o, phys_req_o;
  logic phys_write_o;
  logic [1:0]  op0_i;
  logic [2:0]  op1_i, op2_i;
  logic [3:0]  crn_i, crm_i;
  logic [23:0] hp_g0_id_i, hp_g1_id_i, activate_id_o, eoi_id_o, last;
  logic [31:0] wdata_i, rdata_o, phys_wdata_o, r;
  vcq_dst_t    dst_o;
  int          mismatches, n_tests, seed;
  vcq_regs u_vcq_regs (.*);
  vcq_pe_model u_vcq_pe_model (.core_clk_i, .req_o(req_i), .write_o(write_i), .ns_o(nonsecure_i),
    .guest_o(guest_level_i), .op0_o(op0_i), .op1_o(op1_i), .op2_o(op2_i), .crn_o(crn_i), .crm_o(crm_i),
    .wdata_o(wdata_i));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // Compare one value and count it.
  task automatic chk(input string what, input logic [39:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Reference model of one access; inputs are stable from before the taking edge.
  task automatic run(input logic w, s, g, input logic [3:0] cn, cm, input logic [2:0] o2);
    logic grp0, hit, virt, obs, e_act;
    logic [23:0] id;
    vcq_dst_t d;
    grp0 = cm == 4'h8;
    hit = s && g && cn == 4'hc && (grp0 ? !w && (o2 == 3'h2 || o2 == 3'h0) : cm == 4'hc && o2 == (w ? 3'h1 : 3'h2));
    d = !hit ? VCQ_DST_NONE : !(grp0 ? group0_virtual_route_i : group1_virtual_route_i) ? VCQ_DST_PHYS :
      !sysreg_interface_enable_i ? VCQ_DST_TRAP_GUEST :
      (grp0 ? trap_all_group0_i : trap_all_group1_i) ? VCQ_DST_TRAP_HYP : VCQ_DST_VIRT;
    virt = d == VCQ_DST_VIRT;
    obs = grp0 ? hp_g0_valid_i && (o2 != 3'h0 || hp_g0_signalable_i && hp_g0_ackable_i) : hp_g1_valid_i;
    id = obs ? (grp0 ? hp_g0_id_i : hp_g1_id_i) : 24'h0003ff;
    if (!identifier_width_field_i) id[23:16] = 8'h00;
    e_act = virt && grp0 && o2 == 3'h0 && obs;
    if (e_act) last = id;
    u_vcq_pe_model.access(w, s, g, cn, cm, o2, {8'h00, last});
    chk("results", {ack_o, dst_o, rdata_o, activate_o, drop_prio_o, deactivate_o, phys_req_o}, {1'b1, d,
      (virt && !w) ? {8'h00, id} : 32'h0, e_act, virt && w, virt && w && !split_completion_mode_i,
      d == VCQ_DST_PHYS});
    if (e_act) chk("activation", {sync_o, activate_id_o[15:0]}, {irq_masked_i, id[15:0]});
    if (virt && w) chk("eoi_id", {24'h0, eoi_id_o[15:0]}, {24'h0, last[15:0]});
    if (d == VCQ_DST_PHYS && w) chk("forward", {phys_write_o, phys_wdata_o}, {1'b1, 8'h00, last});
  endtask
  // Closing report for every path.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    seed = 32'h4ea2;
    {irq_masked_i, hp_g1_valid_i, group0_virtual_route_i, group1_virtual_route_i, sysreg_interface_enable_i,
      trap_all_group0_i, trap_all_group1_i, identifier_width_field_i, split_completion_mode_i, hp_g0_valid_i,
      hp_g0_signalable_i, hp_g0_ackable_i, hp_g0_id_i, hp_g1_id_i, last} = '0;
    sys_rst_i = 1'b1;
    repeat (16) @(posedge core_clk_i);
    #1 sys_rst_i = 1'b0;
    // Back-to-back random accesses across every encoding, route and trap; refusals by state, level, CRn, CRm and read-only write.
    for (int i = 0; i < 600; i++) begin
      r = $random(seed);
      {irq_masked_i, hp_g1_valid_i, group0_virtual_route_i, group1_virtual_route_i, sysreg_interface_enable_i,
        trap_all_group0_i, trap_all_group1_i, identifier_width_field_i, split_completion_mode_i, hp_g0_valid_i,
        hp_g0_signalable_i, hp_g0_ackable_i} = r[11:0];
      hp_g0_id_i = {r[31:24], r[15:0]};
      hp_g1_id_i = {r[23:16], r[31:16]};
      case (r[14:12] % 6)
        0: run(1'b0, |r[19:18], |r[21:20], r[24] ? 4'hc : 4'hd, 4'h8, 3'h2);
        1: run(1'b0, |r[19:18], |r[21:20], 4'hc, 4'hc, 3'h2);
        2: run(1'b0, |r[19:18], |r[21:20], 4'hc, 4'h8, 3'h0);
        3: run(1'b1, |r[19:18], |r[21:20], 4'hc, 4'hc, 3'h1);
        4: run(1'b1, 1'b1, 1'b1, 4'hc, r[22] ? 4'h8 : 4'hc, 3'h2);
        default: run(r[23], 1'b1, 1'b1, 4'hc, 4'hb, 3'h1);
      endcase
    end
    u_vcq_pe_model.release_bus();
    @(posedge core_clk_i);
    #1 chk("idle", {ack_o, dst_o, rdata_o}, 36'h0);
    stop_test();
  end
endmodule
`default_nettype wire
